// ---- common/dds_pkg.sv ----
package dds_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SER1_COPY = 8'h20;
   localparam logic [7:0] IDX_SER2_COPY = 8'h21;
   localparam logic [7:0] IDX_DEV_DIS = 8'h22;
   localparam int BYTES_PER_REG = 4;
   // Fifo control copy fields
   localparam int FC_ENABLE_BIT = 0;
   localparam int FC_RX_CLEAR_BIT = 1;
   localparam int FC_TX_CLEAR_BIT = 2;
   localparam int FC_DMA_MODE_BIT = 3;
   localparam int FC_RX_TRIG_LSB = 6;
   localparam int FC_RX_TRIG_MSB = 7;
   localparam logic [7:0] FC_READ_MASK = 8'hcf;
   localparam logic [7:0] FC_COPY_RESET = 8'h00;
   // Device disable fields
   localparam int DD_WP_BIT = 0;
   localparam int DD_DEV_LSB = 3;
   localparam int DD_NUM_DEV = 5;
   localparam logic [7:0] DD_WRITE_MASK = 8'hf9;
   localparam logic [7:0] DD_RESET = 8'h00;
   // Lock field value that hands control to the lock pin
   localparam logic [1:0] LOCK_BY_PIN = 2'b01;
   // Bus answers
   localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
   // Bus transfer phases
   typedef enum logic [1:0] {APB_IDLE, APB_ANSWER} dds_apb_e;
endpackage : dds_pkg

// ---- common/dds_fifo_ctl_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Capture strobe, value and stored copy of one port's fifo control
interface dds_fifo_ctl_if;
   logic wr; // Control write strobe
   logic [7:0] wdata; // Value written
   logic [7:0] copy; // Stored copy
   modport cap (input wr, input wdata, output copy);
   modport use_side (output wr, output wdata, input copy);
endinterface : dds_fifo_ctl_if
`default_nettype wire

// ---- rtl/dds_fifo_ctl_copy.sv ----
`timescale 1ns/1ns
`default_nettype none
// Holds the last fifo control value written to one serial port
module dds_fifo_ctl_copy
(
   input wire logic clk_in, // System clock
   input wire logic reset_in, // Async reset, active high
   input wire logic ce_in, // Clock enable
   dds_fifo_ctl_if.cap fc // Strobe in, copy out
);
   logic [7:0] copy_r; // Stored value

   ////////////////////////////////////////////////////////////////
   // Capture on each write to the port while clock enable is high
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         copy_r <= dds_pkg::FC_COPY_RESET;
      end
      else if (ce_in && fc.wr)
      begin
         copy_r <= fc.wdata; // Last value wins
      end
   end

   assign fc.copy = copy_r;
endmodule : dds_fifo_ctl_copy
`default_nettype wire

// ---- rtl/dds_dev_disable.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////
// Device disable register bank with fifo control copies, APB slave
////////////////////////////////////////////////////////////////////
// Overview of operation
// - Offset 20h reads first port fifo copy
// - Offset 21h reads second port fifo copy
// - Copy bits: enable, rx, tx clear, dma
// - Receive trigger level in bits 7:6
// - Disable register locked by pin when field 01
// - Disable bit one forces device off
// - Bits 3..7: floppy, midi, ser2, ser1, parallel
// - Bit 0 forces floppy write protect
// - Write protect is OR of four terms
// - Bits 2:1 reserved, read zero
module dds_dev_disable
#(
   parameter int ADDR_W = 12, // APB address width
   parameter int NUM_DEV = 5 // Logical devices under disable control
)
(
   input wire logic CLK_SYS_IN, // 20 MHz system clock
   input wire logic RESET_IN, // Async reset, active high
   input wire logic CE_IN, // Clock enable, freezes all state low
   input wire logic PSEL_IN, // APB select
   input wire logic PENABLE_IN, // APB access phase
   input wire logic PWRITE_IN, // APB direction, high writes
   input wire logic [ADDR_W-1:0] PADDR_IN, // APB byte address
   input wire logic [31:0] PWDATA_IN, // APB write data
   output logic [31:0] PRDATA_OUT, // APB read data
   output logic PREADY_OUT, // APB ready
   output logic PSLVERR_OUT, // APB error, unmapped address
   input wire logic SER1_FC_WR_IN, // First port fifo control write
   input wire logic [7:0] SER1_FC_DATA_IN, // First port written value
   input wire logic SER2_FC_WR_IN, // Second port fifo control write
   input wire logic [7:0] SER2_FC_DATA_IN, // Second port written value
   input wire logic [1:0] LOCK_CFG_IN, // Lock pin config field 3:2
   input wire logic LOCK_PIN_IN, // Lock pin level
   input wire logic [NUM_DEV-1:0] ACTIVATE_IN, // Device activate bits
   output logic [NUM_DEV-1:0] DEVICE_ON_OUT, // Device enables
   input wire logic DRIVE0_SELECT_N_IN, // Drive 0 select
   input wire logic DRIVE1_SELECT_N_IN, // Drive 1 select
   input wire logic FORCE_WP_IN, // Forced write protect option
   input wire logic WRITE_PROTECT_N_IN, // Write protect from drive
   output logic WRITE_PROTECT_N_OUT, // Write protect to floppy core
   output logic DEV_DIS_LOCKED_OUT // Disable register locked
);

   ////////////////////////////////////////////////////////////////
   // Elaboration checks
   if (NUM_DEV != dds_pkg::DD_NUM_DEV)
   begin : g_bad_dev
      $error("NUM_DEV must match the five disable bits");
   end
   if (ADDR_W < 10 || ADDR_W > 32)
   begin : g_bad_addr
      $error("ADDR_W must be 10 to 32");
   end

   ////////////////////////////////////////////////////////////////
   // Address constants
   localparam logic [ADDR_W-1:0] A_SER1 =
      ADDR_W'(int'(dds_pkg::IDX_SER1_COPY) * dds_pkg::BYTES_PER_REG);
   localparam logic [ADDR_W-1:0] A_SER2 =
      ADDR_W'(int'(dds_pkg::IDX_SER2_COPY) * dds_pkg::BYTES_PER_REG);
   localparam logic [ADDR_W-1:0] A_DEV_DIS =
      ADDR_W'(int'(dds_pkg::IDX_DEV_DIS) * dds_pkg::BYTES_PER_REG);

   ////////////////////////////////////////////////////////////////
   // Register select decode
   typedef enum logic [1:0] {SEL_NONE, SEL_SER1, SEL_SER2, SEL_DIS}
      dds_sel_e;

   // Maps a byte address to the register it names
   function automatic dds_sel_e reg_sel(input logic [ADDR_W-1:0] a);
      dds_sel_e s;
      s = SEL_NONE;
      if (a == A_SER1)
      begin
         s = SEL_SER1;
      end
      else if (a == A_SER2)
      begin
         s = SEL_SER2;
      end
      else if (a == A_DEV_DIS)
      begin
         s = SEL_DIS;
      end
      return s;
   endfunction : reg_sel

   // Read view of a fifo control copy
   function automatic logic [7:0] fc_view(input logic [7:0] raw);
      logic [7:0] v;
      v = raw & dds_pkg::FC_READ_MASK; // Bits 5:4 read zero
      return v;
   endfunction : fc_view

   ////////////////////////////////////////////////////////////////
   // Internal signals
   logic access_phase; // Select and enable both high
   logic answer_now; // First access cycle, answer goes out
   logic xfer_done; // Access cycle with ready shown
   logic locked_now; // Lock pin holds the disable register
   dds_sel_e sel_now; // Register named by the bus address
   dds_pkg::dds_apb_e apb_state_r; // Bus answer phase
   dds_pkg::dds_apb_e apb_state_nxt; // Next bus answer phase
   logic [31:0] rdata_nxt; // Read value for the answer
   logic [31:0] prdata_r; // Read data flop
   logic pready_r; // Ready flop
   logic pslverr_r; // Error flop
   logic [7:0] dev_dis_r; // Device disable register
   logic locked_r; // Lock flag flop
   logic wp_term; // Write protect before the flop
   logic wp_n_r; // Write protect flop
   logic [NUM_DEV-1:0] device_on_w; // Gathered device enable flops
   logic [7:0] ser1_copy; // First port copy as stored
   logic [7:0] ser2_copy; // Second port copy as stored

   ////////////////////////////////////////////////////////////////
   // Fifo control copies, one per serial port
   dds_fifo_ctl_if fc_port [2] (); // Index 0 first port, 1 second

   // Strobes and values from the serial ports
   assign fc_port[0].wr = SER1_FC_WR_IN;
   assign fc_port[0].wdata = SER1_FC_DATA_IN;
   assign fc_port[1].wr = SER2_FC_WR_IN;
   assign fc_port[1].wdata = SER2_FC_DATA_IN;

   // One capture register per port; host writes never reach them
   for (genvar p = 0; p < 2; p++)
   begin : g_copy
      dds_fifo_ctl_copy u_copy
      (
         .clk_in(CLK_SYS_IN), // System clock
         .reset_in(RESET_IN), // Async reset
         .ce_in(CE_IN), // Clock enable
         .fc(fc_port[p]) // Strobe in, copy out
      );
   end

   // Stored copies as seen by the read mux
   assign ser1_copy = fc_port[0].copy;
   assign ser2_copy = fc_port[1].copy;

   ////////////////////////////////////////////////////////////////
   // Bus decode
   // Select and enable together mark the access phase
   assign access_phase = PSEL_IN && PENABLE_IN;

   // The answer leaves in the first access cycle only
   assign answer_now = access_phase && (apb_state_r == dds_pkg::APB_IDLE);

   // Transfer ends at the edge where ready is seen high
   assign xfer_done = access_phase && pready_r;

   // Full byte address must match, so misaligned words are unmapped
   assign sel_now = reg_sel(PADDR_IN);

   ////////////////////////////////////////////////////////////////
   // Lock decode
   // Pin holds the register only while the field selects pin mode
   assign locked_now = (LOCK_CFG_IN == dds_pkg::LOCK_BY_PIN) && LOCK_PIN_IN;

   ////////////////////////////////////////////////////////////////
   // Bus answer state machine
   // Idle waits for an access; answer holds ready for one cycle
   always_comb
   begin
      apb_state_nxt = apb_state_r;
      unique case (apb_state_r)
         dds_pkg::APB_IDLE:
         begin
            if (access_phase)
            begin
               apb_state_nxt = dds_pkg::APB_ANSWER; // Access seen
            end
         end
         dds_pkg::APB_ANSWER:
         begin
            apb_state_nxt = dds_pkg::APB_IDLE; // Ready shown once
         end
         default:
         begin
            apb_state_nxt = dds_pkg::APB_IDLE; // Unused code, recover
         end
      endcase
   end

   // State flop
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         apb_state_r <= dds_pkg::APB_IDLE;
      end
      else if (CE_IN)
      begin
         apb_state_r <= apb_state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Bus answer flops
   // Ready rises for the cycle after the first access cycle
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         pready_r <= 1'h0;
      end
      else if (CE_IN)
      begin
         pready_r <= answer_now;
      end
   end

   // Error goes out with ready when the address names no register
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         pslverr_r <= 1'h0;
      end
      else if (CE_IN)
      begin
         pslverr_r <= answer_now && (sel_now == SEL_NONE);
      end
   end

   // Read value for the addressed register; unmapped reads give zero
   always_comb
   begin
      rdata_nxt = dds_pkg::RDATA_IDLE;
      unique case (sel_now)
         SEL_SER1:
         begin
            rdata_nxt = {24'h00_0000, fc_view(ser1_copy)};
         end
         SEL_SER2:
         begin
            rdata_nxt = {24'h00_0000, fc_view(ser2_copy)};
         end
         SEL_DIS:
         begin
            rdata_nxt = {24'h00_0000, dev_dis_r & dds_pkg::DD_WRITE_MASK};
         end
         SEL_NONE:
         begin
            rdata_nxt = dds_pkg::RDATA_IDLE; // Nothing at this address
         end
      endcase
   end

   // Read data sampled once, in the first access cycle, and held
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         prdata_r <= dds_pkg::RDATA_IDLE;
      end
      else if (CE_IN && answer_now)
      begin
         if (PWRITE_IN)
         begin
            prdata_r <= dds_pkg::RDATA_IDLE; // Writes return nothing
         end
         else
         begin
            prdata_r <= rdata_nxt; // Reads touch no port
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Device disable register
   // Write lands at the end of the transfer unless the pin holds it
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         dev_dis_r <= dds_pkg::DD_RESET;
      end
      else if (CE_IN && xfer_done && PWRITE_IN && (sel_now == SEL_DIS))
      begin
         if (!locked_now)
         begin
            dev_dis_r <= PWDATA_IN[7:0] & dds_pkg::DD_WRITE_MASK;
         end
      end
   end

   // Lock flag shown to the outside, one cycle behind the pins
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         locked_r <= 1'h0;
      end
      else if (CE_IN)
      begin
         locked_r <= locked_now;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Device enables
   // A set disable bit overrides the device's activate bit
   for (genvar d = 0; d < NUM_DEV; d++)
   begin : g_dev_on
      logic on_r; // Enable flop for this device

      // Disable bit d plus three belongs to device d
      always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
      begin
         if (RESET_IN)
         begin
            on_r <= 1'h0;
         end
         else if (CE_IN)
         begin
            on_r <= ACTIVATE_IN[d] && !dev_dis_r[dds_pkg::DD_DEV_LSB + d];
         end
      end

      assign device_on_w[d] = on_r;
   end

   ////////////////////////////////////////////////////////////////
   // Floppy write protect
   // Four terms ORed; the register bit alone forces protection
   assign wp_term = (DRIVE0_SELECT_N_IN && FORCE_WP_IN) ||
      (DRIVE1_SELECT_N_IN && FORCE_WP_IN) ||
      WRITE_PROTECT_N_IN ||
      dev_dis_r[dds_pkg::DD_WP_BIT];

   // Protected while in reset, so nothing is written before setup
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         wp_n_r <= 1'h1;
      end
      else if (CE_IN)
      begin
         wp_n_r <= wp_term;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flop
   assign PRDATA_OUT = prdata_r;
   assign PREADY_OUT = pready_r;
   assign PSLVERR_OUT = pslverr_r;
   assign DEVICE_ON_OUT = device_on_w;
   assign WRITE_PROTECT_N_OUT = wp_n_r;
   assign DEV_DIS_LOCKED_OUT = locked_r;
endmodule : dds_dev_disable
`default_nettype wire

// ---- tb/dds_dev_disable_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bus and pin checks for the disable bank
module dds_dev_disable_props #(parameter int ADDR_W = 12)
(input wire logic CLK_SYS_IN, RESET_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, // Bus
 input wire logic PSLVERR_OUT, LOCK_PIN_IN, DEV_DIS_LOCKED_OUT, WRITE_PROTECT_N_IN, // Pins
 input wire logic WRITE_PROTECT_N_OUT, input wire logic [1:0] LOCK_CFG_IN, // Lock field
 input wire logic [ADDR_W-1:0] PADDR_IN, input wire logic [31:0] PRDATA_OUT); // Addr, data
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN);
   wire logic dn = PSEL_IN && PENABLE_IN && PREADY_OUT; // Transfer ends
   wire logic rd = dn && !PWRITE_IN; // Read ends
   wire logic mp = 32'(PADDR_IN) inside {32'h80, 32'h84, 32'h88}; // Mapped, aligned
   a_lock_flag:
      assert property ($stable({LOCK_CFG_IN, LOCK_PIN_IN}) |-> DEV_DIS_LOCKED_OUT ==
         (LOCK_CFG_IN == 2'h1 && LOCK_PIN_IN)) else $error("lock flag");
   a_wp_pin:
      assert property (WRITE_PROTECT_N_IN [*2] |-> WRITE_PROTECT_N_OUT) else $error("protect");
   a_ready_due:
      assert property (PSEL_IN && PENABLE_IN |-> ##[0:15] PREADY_OUT) else $error("ready");
   a_copy_resv:
      assert property (rd && mp && !PADDR_IN[3] |-> PRDATA_OUT[5:4] == 2'h0) else $error("copy");
   a_dis_resv:
      assert property (rd && mp && PADDR_IN[3] |-> PRDATA_OUT[2:1] == 2'h0) else $error("dis");
   a_upper_zero:
      assert property (rd |-> PRDATA_OUT[31:8] == 24'h0) else $error("upper");
   a_map_ok:
      assert property (dn && mp |-> !PSLVERR_OUT) else $error("mapped error");
   a_unmap_err:
      assert property (dn && !mp |-> PSLVERR_OUT) else $error("no error");
   cover property (rd && mp && PADDR_IN[3]);
   cover property (DEV_DIS_LOCKED_OUT);
   cover property (dn && !mp);
endmodule : dds_dev_disable_props
bind dds_dev_disable dds_dev_disable_props #(.ADDR_W(ADDR_W)) u_props (.CLK_SYS_IN, .RESET_IN,
 .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PREADY_OUT, .PSLVERR_OUT, .LOCK_PIN_IN, .DEV_DIS_LOCKED_OUT,
 .WRITE_PROTECT_N_IN, .WRITE_PROTECT_N_OUT, .LOCK_CFG_IN, .PADDR_IN, .PRDATA_OUT);
`default_nettype wire

// ---- tb/dds_dev_disable_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module dds_dev_disable_bench;
   logic clk = 1'h0, rst = 1'h1, ce = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0; // Clock, bus
   logic s1w = 1'h0, s2w = 1'h0, lpin = 1'h0, d0 = 1'h0, d1 = 1'h0, fwp = 1'h0; // Pins
   logic wpi = 1'h0; // Write protect from drive
   logic rdy, err, wpo, lck, re; // Design outputs, error taken at the answer
   logic [1:0] lcfg = 2'h0; // Lock field
   logic [4:0] act = 5'h1f, don; // Activates, enables
   logic [4:0] wpt [4] = '{5'h15, 5'h0d, 5'h18, 5'h03}; // Pins then expected protect
   logic [7:0] s1d = 8'h00, s2d = 8'h00; // Port values
   logic [11:0] padr = 12'h000; // Bus address
   logic [31:0] pwd = 32'h0, prd, rv; // Write data, read data, read taken
   int miscompares = 0, checks = 0; // Tallies
   dds_dev_disable u_dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
      .PREADY_OUT(rdy), .PSLVERR_OUT(err), .SER1_FC_WR_IN(s1w), .SER1_FC_DATA_IN(s1d),
      .SER2_FC_WR_IN(s2w), .SER2_FC_DATA_IN(s2d), .LOCK_CFG_IN(lcfg), .LOCK_PIN_IN(lpin),
      .ACTIVATE_IN(act), .DEVICE_ON_OUT(don), .DRIVE0_SELECT_N_IN(d0), .DRIVE1_SELECT_N_IN(d1),
      .FORCE_WP_IN(fwp), .WRITE_PROTECT_N_IN(wpi), .WRITE_PROTECT_N_OUT(wpo),
      .DEV_DIS_LOCKED_OUT(lck));
   // Free-running 20 MHz clock
   initial forever #25 clk = ~clk;

   // Verdict and end of run
   task automatic close_out;
      if (miscompares == 0 && checks > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   // Counts a compare and reports a difference
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // One transfer: setup, then access held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {psel, pwr, padr, pwd} <= {1'h1, w, a, d};
      @(posedge clk);
      pen <= 1'h1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'h1 && n < 30);
      if (rdy !== 1'h1)
      begin
         miscompares++;
         close_out();
      end
      else
      begin
         rv = prd;
         re = err;
         {psel, pen} <= 2'h0;
      end
   endtask : apb

   // Read with the expected byte in the low lane and no error
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'h0, a, 32'h0);
      chk("read data", rv, {24'h00_0000, e});
      chk("read error", {31'h0, re}, 32'h0);
   endtask : rd

   // Scenario sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rd(12'h080, 8'h00);
      rd(12'h084, 8'h00);
      rd(12'h088, 8'h00);
      @(posedge clk);
      {s1w, s1d, s2w, s2d} <= {1'h1, 8'hff, 1'h1, 8'h5a};
      @(posedge clk);
      {s1w, s2w} <= 2'h0;
      rd(12'h080, 8'hcf);
      apb(1'h1, 12'h080, 32'h0);
      rd(12'h080, 8'hcf);
      rd(12'h084, 8'h4a);
      @(posedge clk);
      {ce, s1w, s1d} <= {1'h0, 1'h1, 8'h00};
      @(posedge clk);
      {ce, s1w} <= 2'h2;
      rd(12'h080, 8'hcf); // Copy frozen while clock enable is low
      apb(1'h1, 12'h088, 32'hff);
      rd(12'h088, 8'hf9);
      repeat (2) @(posedge clk);
      chk("device on", {27'h0, don}, 32'h0);
      chk("write protect", {31'h0, wpo}, 32'h1);
      chk("lock flag", {31'h0, lck}, 32'h0);
      @(posedge clk);
      {lcfg, lpin} <= 3'h3;
      apb(1'h1, 12'h088, 32'h0);
      rd(12'h088, 8'hf9);
      chk("lock flag", {31'h0, lck}, 32'h1);
      @(posedge clk);
      {lcfg, lpin} <= 3'h2;
      for (int i = 0; i < 5; i++)
      begin
         apb(1'h1, 12'h088, 32'h8 << i);
         repeat (2) @(posedge clk);
         chk("device on", {27'h0, don}, 32'h1f ^ (32'h1 << i));
      end
      foreach (wpt[k])
      begin
         @(posedge clk);
         {d0, d1, fwp, wpi} <= wpt[k][4:1];
         repeat (2) @(posedge clk);
         chk("write protect", {31'h0, wpo}, {31'h0, wpt[k][0]});
      end
      apb(1'h0, 12'h08c, 32'h0);
      chk("unmapped error", {31'h0, re}, 32'h1);
      chk("unmapped data", rv, 32'h0);
      close_out();
   end
endmodule : dds_dev_disable_bench
`default_nettype wire
